// file: verilog/slfc_pkg.sv
package slfc_pkg;

  // Diagnostic register field positions
  localparam int DG_RSEL0_POS    = 0;
  localparam int DG_RSEL1_POS    = 1;
  localparam int DG_LOOP_LO_POS  = 2;
  localparam int DG_DEFSEL_POS   = 3;
  localparam int DG_UNLOCK_POS   = 4;
  localparam int DG_DLO_POS      = 6;
  localparam logic [3:0] DG_DEFAULT_PAT = 4'hF;

  // Control register field positions
  localparam int CT_DIAG_KEEP_POS = 2;
  localparam int CT_SIB_POS       = 3;

  // Status register layout
  localparam int ST_SYNC_POS  = 0;
  localparam int ST_QUAL_LO   = 1;
  localparam int ST_HK_POS    = 3;
  localparam int ST_REV_POS   = 7;
  localparam logic [2:0] ST_FUTURE = 3'h7;
  localparam logic REVISION_FLAG   = 1'b1; // Arbitrary value

  // Reset values
  localparam logic [7:0] DIAG_RESET = 8'h00;
  localparam logic [7:0] CTRL_RESET = 8'h00;
  localparam logic [7:0] STAT_RESET = 8'hF0;

  // Line frame lengths in bits
  localparam int FRAME_BITS_80  = 10;
  localparam int FRAME_BITS_160 = 20;

  // System clock period in ns (line clock comes as a pin)
  localparam int CLK_PERIOD_NS = 5;

  typedef enum logic [1:0] {
    SLFC_DEF_NONE,
    SLFC_DEF_MODE1,
    SLFC_DEF_MODE2
  } slfc_default_t;

  typedef enum logic [2:0] {
    SLFC_SLOT_SYNC,
    SLFC_SLOT_HK,
    SLFC_SLOT_SIG,
    SLFC_SLOT_B1,
    SLFC_SLOT_B2
  } slfc_slot_t;

endpackage : slfc_pkg

// file: verilog/slfc_sync2.sv
`timescale 1ns/1ps
`default_nettype none
module slfc_sync2
  import slfc_pkg::*;
#(
  parameter int W = 1
) (
  input  wire logic         i_clk,
  input  wire logic         i_rst_b,
  input  wire logic [W-1:0] i_async,
  output logic      [W-1:0] o_sync
);
  logic [W-1:0] meta_q;
  logic [W-1:0] sync_q;

  // First stage feeds only the second
  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      meta_q <= '0;
      sync_q <= '0;
    end else begin
      meta_q <= i_async;
      sync_q <= meta_q;
    end
  end

  assign o_sync = sync_q;
endmodule : slfc_sync2
`default_nettype wire

// file: verilog/slfc_line_coder.sv
`timescale 1ns/1ps
`default_nettype none
// How it works
// [RQ1] Diag bits 4-7 all one picks default mode
// [RQ2] Controller avoids line loopback in network slave
// [RQ3] Controller avoids data loopback in modem master
// [RQ4] Control bit2 zero clears diag at frame
// [RQ5] Controller rewrites diag register to keep it
// [RQ6] Status byte goes out on control channel
// [RQ7] Status bit0 shows line sync lock
// [RQ8] Status bits 1-2 carry channel quality
// [RQ9] Status bit3 holds last received housekeeping
// [RQ10] Status bits 4-6 always read one
// [RQ11] Status bit7 is fixed revision flag
// [RQ12] Modem mode: control port plain serial stream
// [RQ13] Modem control bits move on bit clock
// [RQ14] Differential encode: out is prev xor data
// [RQ15] Biphase: rising mid-cell one, falling zero
// [RQ16] Line held at bias when disabled
// [RQ17] 80k frame: sync, one signalling, B1
// [RQ18] 160k frame: sync, hk, two signalling, B1, B2
// [RQ19] Signalling-in-bearer sends signalling in B1
// [RQ20] Modem mode sends unframed continuous stream
// [RQ21] Feeder sends a one after power-up
// [RQ22] Diag bit4 forces receiver out of sync
// [RQ23] Controller selects diag with select bits 0,1
// [RQ24] Status byte refreshed once per frame
module slfc_line_coder
  import slfc_pkg::*;
(
  input  wire logic       i_clk,
  input  wire logic       i_rst_b,
  input  wire logic       i_bit_clk,
  input  wire logic       i_frame_pulse,
  input  wire logic       i_line_tx_disable_pin,
  input  wire logic       i_modem_mode,
  input  wire logic       i_rate_160,
  input  wire logic       i_ctrl_wr,
  input  wire logic [7:0] i_ctrl_data,
  input  wire logic       i_diag_wr,
  input  wire logic [7:0] i_diag_data,
  input  wire logic       i_tx_data,
  input  wire logic       i_sig_data,
  input  wire logic       i_rx_sync_lock,
  input  wire logic [1:0] i_channel_quality,
  input  wire logic       i_rx_housekeeping_bit,
  input  wire logic       i_tx_housekeeping_bit,
  input  wire logic       i_control_port_in,
  output logic            o_line_out,
  output logic            o_line_bias,
  output logic            o_line_data_req,
  output logic [2:0]      o_slot,
  output logic            o_control_port,
  output logic            o_channel_delimiter,
  output logic            o_ctrl_bit_valid,
  output logic            o_ctrl_bit,
  output logic [7:0]      o_line_status,
  output logic [7:0]      o_diag,
  output logic [1:0]      o_default_mode,
  output logic            o_force_unlock_bit,
  output logic            o_signalling_in_bearer
);

  // Bit clock, frame pulse, disable and control input pins pass two stages first
  logic [3:0] pin_s;
  slfc_sync2 #(.W(4)) u_sync (
    .i_clk   (i_clk),
    .i_rst_b (i_rst_b),
    .i_async ({i_bit_clk, i_frame_pulse, i_line_tx_disable_pin,
               i_control_port_in}),
    .o_sync  (pin_s)
  );

  wire bclk_s  = pin_s[3];
  wire fp_s    = pin_s[2];
  wire dis_s   = pin_s[1];
  wire cpin_s  = pin_s[0];

  logic bclk_q;
  logic fp_q;
  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      bclk_q <= 1'b0;
      fp_q   <= 1'b0;
    end else begin
      bclk_q <= bclk_s;
      fp_q   <= fp_s;
    end
  end

  wire bclk_rise = bclk_s & ~bclk_q;
  wire bclk_fall = ~bclk_s & bclk_q;
  wire fp_rise   = fp_s & ~fp_q;

  // Control and diagnostic registers
  logic [7:0] ctrl_q;
  logic [7:0] diag_q;
  logic       clr_pend_q;

  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      ctrl_q <= CTRL_RESET;
    end else if (i_ctrl_wr) begin
      ctrl_q <= i_ctrl_data;
    end
  end

  // Clear is armed by a control write and fires at the frame pulse
  wire ctrl_arms_clr = i_ctrl_wr & ~i_ctrl_data[CT_DIAG_KEEP_POS];
  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      clr_pend_q <= 1'b0;
    end else if (ctrl_arms_clr) begin
      clr_pend_q <= 1'b1; // RQ4
    end else if (i_ctrl_wr || fp_rise) begin
      clr_pend_q <= 1'b0; // RQ4
    end
  end

  // A write landing with the frame pulse survives the clear
  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      diag_q <= DIAG_RESET;
    end else if (i_diag_wr) begin
      diag_q <= i_diag_data;
    end else if (clr_pend_q && fp_rise) begin
      diag_q <= DIAG_RESET; // RQ4
    end
  end

  function automatic slfc_default_t slfc_decode_default(
    input logic [7:0] d
  );
    if (d[7:DG_UNLOCK_POS] != DG_DEFAULT_PAT) begin
      return SLFC_DEF_NONE;
    end
    return d[DG_DEFSEL_POS] ? SLFC_DEF_MODE2 : SLFC_DEF_MODE1;
  endfunction : slfc_decode_default

  wire slfc_default_t def_mode = slfc_decode_default(diag_q); // RQ1
  wire def_active = (def_mode != SLFC_DEF_NONE);
  assign o_default_mode = def_mode;
  assign o_diag         = diag_q;

  // Diagnostic features are off while a default mode is in force
  assign o_force_unlock_bit = diag_q[DG_UNLOCK_POS] & ~def_active; // RQ22
  wire dlo_bit = diag_q[DG_DLO_POS] & ~def_active;
  assign o_signalling_in_bearer = ctrl_q[CT_SIB_POS];

  // Bit timing: a bit cell starts on bit clock rise, mid-cell on fall
  logic [4:0] bitpos_q;
  wire [4:0] frame_len = i_rate_160 ? 5'(FRAME_BITS_160)
                                    : 5'(FRAME_BITS_80);
  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      bitpos_q <= 5'h00;
    end else if (fp_rise) begin
      bitpos_q <= 5'h00;
    end else if (bclk_rise) begin
      bitpos_q <= (bitpos_q == frame_len - 5'h01) ? 5'h00
                                                   : bitpos_q + 5'h01;
    end
  end

  // Slot map within a frame
  function automatic slfc_slot_t slfc_slot_of(
    input logic [4:0] p,
    input logic       r160,
    input logic       sib
  );
    if (p == 5'h00) begin
      return SLFC_SLOT_SYNC;
    end
    if (r160) begin
      if (p == 5'h01) return SLFC_SLOT_HK;
      if (p <= 5'h03 && !sib) return SLFC_SLOT_SIG;
      if (p <= 5'h0B) return SLFC_SLOT_B1;
      return SLFC_SLOT_B2;
    end
    if (p == 5'h01 && !sib) return SLFC_SLOT_SIG;
    return SLFC_SLOT_B1;
  endfunction : slfc_slot_of

  wire slfc_slot_t slot_now =
    i_modem_mode ? SLFC_SLOT_B1 // RQ20
                 : slfc_slot_of(bitpos_q, i_rate_160,
                                ctrl_q[CT_SIB_POS]); // RQ17 RQ18 RQ19
  assign o_slot = slot_now;
  assign o_line_data_req = bclk_rise;

  // Sync marker alternates per frame as a simple pattern
  logic sync_bit_q;
  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      sync_bit_q <= 1'b0;
    end else if (fp_rise) begin
      sync_bit_q <= ~sync_bit_q;
    end
  end

  logic slot_bit;
  always_comb begin
    unique case (slot_now)
      SLFC_SLOT_SYNC: slot_bit = sync_bit_q;
      SLFC_SLOT_HK:   slot_bit = i_tx_housekeeping_bit;
      SLFC_SLOT_SIG:  slot_bit = i_sig_data;
      SLFC_SLOT_B1:   slot_bit = (ctrl_q[CT_SIB_POS] && !i_modem_mode)
                                 ? i_sig_data : i_tx_data; // RQ19
      SLFC_SLOT_B2:   slot_bit = i_tx_data;
      default:        slot_bit = 1'b0;
    endcase
  end

  // Differential and biphase coding
  logic diff_q;
  logic line_q;
  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      diff_q <= 1'b0;
      line_q <= 1'b0;
    end else if (bclk_rise) begin
      diff_q <= diff_q ^ slot_bit; // RQ14
      line_q <= ~(diff_q ^ slot_bit); // RQ15
    end else if (bclk_fall) begin
      line_q <= diff_q; // RQ15
    end
  end

  // Bias is a separate flag since the pin is analogue in reality
  wire line_off = dis_s | dlo_bit;
  assign o_line_out  = line_off ? 1'b0 : line_q; // RQ16
  assign o_line_bias = line_off; // RQ16

  // Status byte, latched once per frame
  wire [7:0] stat_now = {REVISION_FLAG, ST_FUTURE, // RQ10 RQ11
                         i_rx_housekeeping_bit, // RQ9
                         i_channel_quality, // RQ8
                         i_rx_sync_lock & ~i_modem_mode
                           & ~o_force_unlock_bit}; // RQ7 RQ22
  logic [7:0] stat_q;
  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      stat_q <= STAT_RESET;
    end else if (fp_rise) begin
      stat_q <= stat_now; // RQ24
    end
  end
  assign o_line_status = stat_q;

  // Control channel: 8-bit serial stream, MSB first, on bit clock
  logic [7:0] csh_q;
  logic [2:0] ccnt_q;
  logic       cdl_q;
  logic       cval_q;
  logic       cbit_q;
  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      csh_q  <= STAT_RESET;
      ccnt_q <= 3'h0;
      cdl_q  <= 1'b0;
    end else if (fp_rise && !i_modem_mode) begin
      csh_q  <= stat_now; // RQ6
      ccnt_q <= 3'h0;
      cdl_q  <= 1'b1;
    end else if (bclk_rise) begin
      ccnt_q <= ccnt_q + 3'h1; // RQ13
      cdl_q  <= (ccnt_q == 3'h7); // RQ13
      csh_q  <= (ccnt_q == 3'h7) ? stat_q
                                 : {csh_q[6:0], 1'b1}; // RQ6 RQ12
    end
  end

  // In modem mode the port carries only the control channel
  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      cval_q <= 1'b0;
      cbit_q <= 1'b0;
    end else begin
      cval_q <= bclk_fall; // RQ13
      if (bclk_fall) begin
        cbit_q <= cpin_s; // RQ12
      end
    end
  end

  assign o_control_port      = csh_q[7];
  assign o_channel_delimiter = cdl_q;
  assign o_ctrl_bit_valid    = cval_q;
  assign o_ctrl_bit          = cbit_q;

  // Assertions
  sequence s_bit_edge;
    bclk_rise;
  endsequence

  a_status_fixed: assert property (@(posedge i_clk) disable iff (!i_rst_b)
    stat_q[6:4] == ST_FUTURE && stat_q[7] == REVISION_FLAG) // RQ10
    else $error("status fixed bits wrong");

  a_status_rev: assert property (@(posedge i_clk) disable iff (!i_rst_b)
    fp_rise |=> stat_q[ST_REV_POS] == REVISION_FLAG) // RQ11
    else $error("revision flag wrong");

  a_diff_code: assert property (@(posedge i_clk) disable iff (!i_rst_b)
    s_bit_edge |=> diff_q == ($past(diff_q) ^ $past(slot_bit))) // RQ14
    else $error("differential code wrong");

  a_biphase_mid: assert property (@(posedge i_clk) disable iff (!i_rst_b)
    bclk_fall |=> line_q == $past(diff_q)) // RQ15
    else $error("biphase mid-cell level wrong");

  a_line_gate: assert property (@(posedge i_clk) disable iff (!i_rst_b)
    (dis_s || dlo_bit) |-> o_line_bias && !o_line_out) // RQ16
    else $error("line not held at bias");

  a_diag_clear: assert property (@(posedge i_clk) disable iff (!i_rst_b)
    (clr_pend_q && fp_rise && !i_diag_wr) |=> diag_q == DIAG_RESET) // RQ4
    else $error("diag not cleared at frame");

  a_diag_keep: assert property (@(posedge i_clk) disable iff (!i_rst_b)
    (!clr_pend_q && !i_diag_wr) |=> $stable(diag_q)) // RQ4
    else $error("diag changed without cause");

  a_status_frame: assert property (@(posedge i_clk) disable iff (!i_rst_b)
    fp_rise |=> stat_q[ST_HK_POS] == $past(i_rx_housekeeping_bit)) // RQ9 RQ24
    else $error("status not refreshed");

  a_sync_modem: assert property (@(posedge i_clk) disable iff (!i_rst_b)
    (fp_rise && i_modem_mode) |=> !stat_q[ST_SYNC_POS]) // RQ7
    else $error("sync shown in modem mode");

  a_default_sel: assert property (@(posedge i_clk) disable iff (!i_rst_b)
    diag_q[7:4] == DG_DEFAULT_PAT |-> o_default_mode != SLFC_DEF_NONE) // RQ1
    else $error("default mode not entered");

  a_ctrl_load: assert property (@(posedge i_clk) disable iff (!i_rst_b)
    fp_rise && !i_modem_mode |=> cdl_q && csh_q == $past(stat_now)) // RQ6
    else $error("control byte not loaded at frame");

  a_ctrl_in: assert property (@(posedge i_clk) disable iff (!i_rst_b)
    bclk_fall |=> cval_q && cbit_q == $past(cpin_s)) // RQ13
    else $error("control input bit not taken");

  a_unlock_sync: assert property (@(posedge i_clk) disable iff (!i_rst_b)
    fp_rise && o_force_unlock_bit |=> !stat_q[ST_SYNC_POS]) // RQ22
    else $error("sync shown while forced unlocked");

endmodule : slfc_line_coder
`default_nettype wire

// file: test/slfc_tdm_ctrl.sv
`timescale 1ns/1ps
`default_nettype none
// System-side bus controller: bit clock, frame pulse, serial control bits
module slfc_tdm_ctrl (
  input  wire logic i_rate_160,
  output logic      o_bit_clk,
  output logic      o_frame_pulse,
  output logic      o_ctrl_out
);
  int pos;
  initial begin
    pos = 0;
    o_bit_clk = 1'b0;
    o_frame_pulse = 1'b0;
    o_ctrl_out = 1'b0;
    forever begin
      #32;
      o_bit_clk = 1'b1;
      o_frame_pulse = (pos == 0);
      // Changes only at cell start; stable over the sampling fall
      o_ctrl_out = pos[0] ^ pos[2];
      #32;
      o_bit_clk = 1'b0;
      o_frame_pulse = 1'b0;
      pos = (pos + 1) % (i_rate_160 ? 20 : 10);
    end
  end
endmodule : slfc_tdm_ctrl
`default_nettype wire

// file: test/slfc_line_coder_tb.sv
`timescale 1ns/1ps
`default_nettype none
module slfc_line_coder_tb;
  import slfc_pkg::*;
  logic i_clk = 1'b0, i_rst_b = 1'b0, bclk, fp, cp_in;
  logic dis_pin = 1'b0, modem = 1'b0, r160 = 1'b0;
  logic c_wr = 1'b0, d_wr = 1'b0, tx_d = 1'b1, sync_lk = 1'b0, rx_housekeeping_bit = 1'b0;
  logic [7:0] wdat = 8'h00;
  logic [1:0] qual = 2'h0;
  logic       line_out, bias, dreq, cport, dlm, cbv, cbit, unl, sib, lo_q;
  logic [2:0] slot;
  logic [7:0] status, diag;
  logic [1:0] dmode;
  int         cnt [5];
  int         n_rise, n_req, n_cbv, error_cnt = 0, n_compared = 0;
  always #2.5 i_clk = ~i_clk;
  slfc_tdm_ctrl slfc_tdm_ctrl_i (.i_rate_160(r160), .o_bit_clk(bclk),
    .o_frame_pulse(fp), .o_ctrl_out(cp_in));
  slfc_line_coder slfc_line_coder_i (.i_clk(i_clk), .i_rst_b(i_rst_b),
    .i_bit_clk(bclk), .i_frame_pulse(fp), .i_line_tx_disable_pin(dis_pin),
    .i_modem_mode(modem), .i_rate_160(r160), .i_ctrl_wr(c_wr),
    .i_ctrl_data(wdat), .i_diag_wr(d_wr), .i_diag_data(wdat),
    .i_tx_data(tx_d), .i_sig_data(1'b1), .i_rx_sync_lock(sync_lk),
    .i_channel_quality(qual), .i_rx_housekeeping_bit(rx_housekeeping_bit),
    .i_tx_housekeeping_bit(1'b1), .i_control_port_in(cp_in),
    .o_line_out(line_out), .o_line_bias(bias), .o_line_data_req(dreq),
    .o_slot(slot), .o_control_port(cport), .o_channel_delimiter(dlm),
    .o_ctrl_bit_valid(cbv), .o_ctrl_bit(cbit), .o_line_status(status),
    .o_diag(diag), .o_default_mode(dmode), .o_force_unlock_bit(unl),
    .o_signalling_in_bearer(sib));
  // Slot occupancy and line rising edges seen within one frame
  always @(posedge i_clk) begin
    lo_q <= line_out;
    if (slot < 3'h5) cnt[slot]++;
    if (line_out === 1'b1 && lo_q === 1'b0) n_rise++;
    if (dreq === 1'b1) tx_d <= ~tx_d;
    if (dreq === 1'b1) n_req++;
    if (cbv === 1'b1) n_cbv++;
  end
  task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
    n_compared++;
    if (g !== e) begin
      error_cnt++;
      $display("mismatch %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  task automatic wr(input logic is_diag, input logic [7:0] d);
    @(posedge i_clk);
    d_wr <= is_diag;
    c_wr <= ~is_diag;
    wdat <= d;
    @(posedge i_clk);
    d_wr <= 1'b0;
    c_wr <= 1'b0;
    @(posedge i_clk);
    #1;
  endtask : wr
  // Waits a whole frame so counters span exactly one frame
  task automatic frame();
    @(posedge fp);
    repeat (8) @(posedge i_clk);
    #1;
    foreach (cnt[k]) cnt[k] = 0;
    n_rise = 0;
    n_req = 0;
    n_cbv = 0;
    @(posedge fp);
    repeat (8) @(posedge i_clk);
    #1;
  endtask : frame
  // Reads one control byte from frame start, sampled late in each cell
  task automatic ser_chk(input logic [7:0] e);
    logic [7:0] b;
    logic [7:0] c;
    @(posedge fp);
    for (int k = 0; k < 8; k++) begin
      repeat (12) @(posedge i_clk);
      #1;
      b = {b[6:0], cport};
      c = {c[6:0], cbit};
      chk("delim", {7'h0, k == 0}, {7'h0, dlm});
      @(posedge bclk);
    end
    chk("ser_out", e, b);
    chk("ser_in", 8'h5A, c);
  endtask : ser_chk
  task automatic print_verdict();
    if (error_cnt == 0 && n_compared > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask : print_verdict
  initial begin
    #200us;
    error_cnt++;
    print_verdict();
  end
  initial begin
    repeat (5) @(posedge i_clk);
    i_rst_b <= 1'b1;
    chk("diag_rst", 8'h00, diag);
    chk("stat_fut", 8'h07, {5'h0, status[6:4]});
    sync_lk <= 1'b1;
    qual <= 2'h2;
    rx_housekeeping_bit <= 1'b1;
    frame();
    chk("status", {REVISION_FLAG, 3'h7, 1'b1, 2'h2, 1'b1}, status);
    chk("sync_slot", 8'h01, 8'(cnt[SLFC_SLOT_SYNC] > 0));
    chk("sig_slot", 8'h01, 8'(cnt[SLFC_SLOT_SIG] > 0));
    chk("hk80", 8'h00, 8'(cnt[SLFC_SLOT_HK] + cnt[SLFC_SLOT_B2]));
    chk("biphase", 8'h01, 8'(n_rise >= 4));
    chk("req_cnt", 8'(FRAME_BITS_80), 8'(n_req));
    chk("cin_cnt", 8'(FRAME_BITS_80), 8'(n_cbv));
    ser_chk({REVISION_FLAG, 3'h7, 1'b1, 2'h2, 1'b1});
    sync_lk <= 1'b0;
    qual <= 2'h1;
    rx_housekeeping_bit <= 1'b0;
    frame();
    chk("status2", {REVISION_FLAG, 3'h7, 1'b0, 2'h1, 1'b0}, status);
    r160 <= 1'b1;
    frame();
    frame();
    chk("hk160", 8'h01, 8'(cnt[SLFC_SLOT_HK] > 0));
    chk("b2_160", 8'h01, 8'(cnt[SLFC_SLOT_B2] > 0));
    chk("req160", 8'(FRAME_BITS_160), 8'(n_req));
    wr(1'b0, 8'h0C);
    chk("sib", 8'h01, {7'h0, sib});
    frame();
    chk("sib_slot", 8'h00, 8'(cnt[SLFC_SLOT_SIG]));
    modem <= 1'b1;
    frame();
    chk("modem", 8'h00, 8'(cnt[0] + cnt[1] + cnt[2]));
    modem <= 1'b0;
    // Select bits 0,1 = 0,1 and loopback bits kept at zero
    wr(1'b1, 8'h12);
    chk("unlock", 8'h01, {7'h0, unl});
    frame();
    chk("diag_keep", 8'h12, diag);
    wr(1'b1, 8'h42);
    chk("dlo_bias", 8'h01, {7'h0, bias});
    frame();
    chk("dlo_quiet", 8'h00, 8'(n_rise));
    wr(1'b1, 8'hF2);
    chk("defmode1", 8'h01, {6'h0, dmode});
    wr(1'b1, 8'hFA);
    chk("defmode2", 8'h02, {6'h0, dmode});
    wr(1'b0, 8'h00);
    frame();
    chk("diag_clr", 8'h00, diag);
    dis_pin <= 1'b1;
    repeat (6) @(posedge i_clk);
    #1;
    chk("pin_bias", 8'h01, {7'h0, bias});
    chk("pin_line", 8'h00, {7'h0, line_out});
    print_verdict();
  end
endmodule : slfc_line_coder_tb
`default_nettype wire
